/* hw/tfp_pkg.sv */
// Package for the 16-bit timer PWM waveform block.
// Assumes a single AHB-Lite slave on hclk with word-aligned registers.
package tfp_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CMP_A = 8'h04;
   localparam logic [7:0] OFF_CMP_B = 8'h08;
   localparam logic [7:0] OFF_CAP_TOP = 8'h0c;
   localparam logic [7:0] OFF_COUNT = 8'h10;
   localparam logic [7:0] OFF_FLAGS = 8'h14;
   // Control field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_ACT_A_LSB = 4;
   localparam int CTRL_ACT_B_LSB = 6;
   localparam int CTRL_PRE_LSB = 8;
   localparam int CTRL_DIR_A = 11;
   localparam int CTRL_DIR_B = 12;
   // Flag bit positions
   localparam int FLG_OVF = 0;
   localparam int FLG_CMP_A = 1;
   localparam int FLG_CMP_B = 2;
   localparam int FLG_CAP = 3;
   // Fixed TOP values
   localparam logic [15:0] TOP_8 = 16'h00ff;
   localparam logic [15:0] TOP_9 = 16'h01ff;
   localparam logic [15:0] TOP_10 = 16'h03ff;
   localparam logic [15:0] CNT_MAX = 16'hffff;
   localparam logic [15:0] CNT_BOTTOM = 16'h0000;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
   // Waveform modes
   typedef enum logic [3:0]
   {
      TFP_M_OFF = 4'h0,
      TFP_M_PC8 = 4'h1,
      TFP_M_PC9 = 4'h2,
      TFP_M_PC10 = 4'h3,
      TFP_M_FP8 = 4'h5,
      TFP_M_FP9 = 4'h6,
      TFP_M_FP10 = 4'h7,
      TFP_M_PCCAP = 4'ha,
      TFP_M_PCCMP = 4'hb,
      TFP_M_FPCAP = 4'he,
      TFP_M_FPCMP = 4'hf
   } tfp_mode_t;
   // Output actions
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_NONINV = 2'h2;
   localparam logic [1:0] ACT_INV = 2'h3;
   // Prescaler selections: 1, 8, 64, 256, 1024
   localparam logic [2:0] PRE_STOP = 3'h0;
   localparam logic [2:0] PRE_1 = 3'h1;
   localparam logic [2:0] PRE_8 = 3'h2;
   localparam logic [2:0] PRE_64 = 3'h3;
   localparam logic [2:0] PRE_256 = 3'h4;
   localparam logic [2:0] PRE_1024 = 3'h5;
   localparam logic [9:0] DIV_8 = 10'h007;
   localparam logic [9:0] DIV_64 = 10'h03f;
   localparam logic [9:0] DIV_256 = 10'h0ff;
   localparam logic [9:0] DIV_1024 = 10'h3ff;
endpackage : tfp_pkg

/* hw/tfp_pwm.sv */
// 16-bit timer waveform generator: fast and phase correct PWM.
// Assumes one AHB-Lite master, single word transfers, always OKAY.
// Notes on behaviour
// - fast PWM counts up to mode's TOP
// - at TOP, next timer cycle clears count
// - overflow at TOP; TOP register flag too
// - fixed TOP masks high compare bits
// - capture TOP unbuffered; missed match wraps
// - compare A buffered, loaded at fast TOP
// - action 2 non-inverted, 3 inverted
// - pin visible only when direction is output
// - compare zero spike; compare TOP constant
// - action 1 toggles A in mode 15
// - modes 1,2,3,10,11 count up/down
// - phase TOP per mode, held one cycle
// - phase: clear on up, set on down
// - phase overflow at BOTTOM, loads at TOP
// - phase period starts and ends at TOP
// - prescaler divides by 1,8,64,256,1024
// - action 0 leaves output, pin to port
// - reset clears output registers
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ns
module tfp_pwm
   import tfp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic port_data_a,
   input wire logic port_data_b,
   output logic compare_output_a,
   output logic compare_output_b,
   output logic compare_output_a_oe_n,
   output logic compare_output_b_oe_n
);
   import tfp_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   logic [12:0] ctrl, next_ctrl;
   logic [15:0] cmp_buf_a, next_cmp_buf_a, cmp_buf_b, next_cmp_buf_b;
   logic [15:0] cmp_a, next_cmp_a, cmp_b, next_cmp_b;
   logic [15:0] capture_top_reg, next_capture_top_reg;
   logic [15:0] count_value, next_count_value;
   logic count_down, next_count_down;
   logic [3:0] flags, next_flags;
   logic oc_a, next_oc_a, oc_b, next_oc_b;
   logic [9:0] pre_cnt, next_pre_cnt;
   logic tick, next_tick;
   logic wr_pend, next_wr_pend;
   logic [7:0] addr_q, next_addr_q;
   logic [31:0] next_hrdata;
   logic next_pin_a, next_pin_b, next_oe_a_n, next_oe_b_n;

   tfp_mode_t mode;
   logic [1:0] output_action_sel_a, output_action_sel_b;
   logic [2:0] pre_sel;
   logic is_fast, is_phase, fixed_top, at_top, at_bottom;
   logic [15:0] top, wmask, wdata16;
   logic match_a, match_b;

   assign mode = tfp_mode_t'(ctrl[CTRL_MODE_LSB +: 4]);
   assign output_action_sel_a = ctrl[CTRL_ACT_A_LSB +: 2];
   assign output_action_sel_b = ctrl[CTRL_ACT_B_LSB +: 2];
   assign pre_sel = ctrl[CTRL_PRE_LSB +: 3];
   assign wdata16 = hwdata[15:0];

   ////////////////////////////////////////////////////////////////////////
   // Mode decode and TOP selection
   always_comb
   begin
      is_fast = 1'b0;
      is_phase = 1'b0;
      fixed_top = 1'b1;
      top = TOP_8;
      case (mode)
         TFP_M_FP8: is_fast = 1'b1;
         TFP_M_FP9:
         begin
            is_fast = 1'b1;
            top = TOP_9;
         end
         TFP_M_FP10:
         begin
            is_fast = 1'b1;
            top = TOP_10;
         end
         TFP_M_FPCAP:
         begin
            is_fast = 1'b1;
            fixed_top = 1'b0;
            top = capture_top_reg;
         end
         TFP_M_FPCMP:
         begin
            is_fast = 1'b1;
            fixed_top = 1'b0;
            top = cmp_a;
         end
         TFP_M_PC8: is_phase = 1'b1;
         TFP_M_PC9:
         begin
            is_phase = 1'b1;
            top = TOP_9;
         end
         TFP_M_PC10:
         begin
            is_phase = 1'b1;
            top = TOP_10;
         end
         TFP_M_PCCAP:
         begin
            is_phase = 1'b1;
            fixed_top = 1'b0;
            top = capture_top_reg;
         end
         TFP_M_PCCMP:
         begin
            is_phase = 1'b1;
            fixed_top = 1'b0;
            top = cmp_a;
         end
         default: fixed_top = 1'b0;
      endcase
      // Mask above fixed resolution on compare writes
      wmask = (fixed_top && (is_fast || is_phase)) ? top : CNT_MAX;
   end

   assign at_top = (count_value == top);
   assign at_bottom = (count_value == CNT_BOTTOM);
   assign match_a = (count_value == cmp_a);
   assign match_b = (count_value == cmp_b);

   ////////////////////////////////////////////////////////////////////////
   // Prescaler: tick is a one-cycle timer enable
   always_comb
   begin
      next_pre_cnt = pre_cnt + 10'h001;
      next_tick = 1'b0;
      case (pre_sel)
         PRE_1: next_tick = 1'b1;
         PRE_8: next_tick = (pre_cnt[2:0] == DIV_8[2:0]);
         PRE_64: next_tick = (pre_cnt[5:0] == DIV_64[5:0]);
         PRE_256: next_tick = (pre_cnt[7:0] == DIV_256[7:0]);
         PRE_1024: next_tick = (pre_cnt == DIV_1024);
         default: next_pre_cnt = 10'h000; // Stopped
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus, counter, compare and output logic
   always_comb
   begin
      next_ctrl = ctrl;
      next_cmp_buf_a = cmp_buf_a;
      next_cmp_buf_b = cmp_buf_b;
      next_cmp_a = cmp_a;
      next_cmp_b = cmp_b;
      next_capture_top_reg = capture_top_reg;
      next_count_value = count_value;
      next_count_down = count_down;
      next_flags = flags;
      next_oc_a = oc_a;
      next_oc_b = oc_b;
      next_hrdata = RESET_WORD;
      // Address phase capture; slave is zero wait state
      next_wr_pend = hsel && hready && htrans[1] && hwrite;
      next_addr_q = (hsel && hready && htrans[1]) ? haddr : addr_q;

      // Timer step, only on the enable
      if (tick)
      begin
         if (is_fast)
         begin
            if (at_top)
            begin
               next_count_value = CNT_BOTTOM;
               next_flags[FLG_OVF] = 1'b1;
               next_cmp_a = cmp_buf_a;
               next_cmp_b = cmp_buf_b;
               if (mode == TFP_M_FPCMP)
                  next_flags[FLG_CMP_A] = 1'b1;
               if (mode == TFP_M_FPCAP)
                  next_flags[FLG_CAP] = 1'b1;
            end
            else
               next_count_value = count_value + 16'h0001;
            // Match actions, then TOP->BOTTOM action at TOP; a match at TOP wins
            if (match_a)
            begin
               next_flags[FLG_CMP_A] = 1'b1;
               if (output_action_sel_a == ACT_NONINV)
                  next_oc_a = 1'b1;
               else if (output_action_sel_a == ACT_INV)
                  next_oc_a = 1'b0;
               else if (output_action_sel_a == ACT_TOGGLE &&
                        mode == TFP_M_FPCMP)
                  next_oc_a = !oc_a;
            end
            if (match_b)
            begin
               next_flags[FLG_CMP_B] = 1'b1;
               if (output_action_sel_b == ACT_NONINV)
                  next_oc_b = 1'b1;
               else if (output_action_sel_b == ACT_INV)
                  next_oc_b = 1'b0;
            end
            // Compare at TOP keeps level constant; compare 0 gives spike
            if (at_top && !match_a && output_action_sel_a[1])
               next_oc_a = output_action_sel_a[0];
            if (at_top && !match_b && output_action_sel_b[1])
               next_oc_b = output_action_sel_b[0];
         end
         else if (is_phase)
         begin
            if (!count_down)
            begin
               if (at_top)
               begin
                  // TOP stands one cycle only, then turn; loads at TOP
                  next_count_down = 1'b1;
                  next_count_value = count_value - 16'h0001;
                  next_cmp_a = cmp_buf_a;
                  next_cmp_b = cmp_buf_b;
                  if (mode == TFP_M_PCCMP)
                     next_flags[FLG_CMP_A] = 1'b1;
                  if (mode == TFP_M_PCCAP)
                     next_flags[FLG_CAP] = 1'b1;
               end
               else
                  next_count_value = count_value + 16'h0001;
            end
            else
            begin
               next_count_value = count_value - 16'h0001;
               if (count_value == 16'h0001)
               begin
                  next_count_down = 1'b0;
                  next_flags[FLG_OVF] = 1'b1;
               end
            end
            if (match_a)
            begin
               next_flags[FLG_CMP_A] = 1'b1;
               if (output_action_sel_a[1])
                  next_oc_a = output_action_sel_a[0] ^ count_down;
               else if (output_action_sel_a == ACT_TOGGLE &&
                        mode == TFP_M_PCCMP)
                  next_oc_a = !oc_a;
            end
            if (match_b)
            begin
               next_flags[FLG_CMP_B] = 1'b1;
               if (output_action_sel_b[1])
                  next_oc_b = output_action_sel_b[0] ^ count_down;
            end
         end
         else
            next_count_value = count_value + 16'h0001;
      end

      // A stale down direction would wrap a zeroed count
      if (!is_phase)
         next_count_down = 1'b0;

      // Register writes; set of a flag wins over its clear only if the flag was clear
      if (wr_pend)
      begin
         if (addr_q == OFF_CTRL)
            next_ctrl = hwdata[12:0];
         else if (addr_q == OFF_CMP_A)
            next_cmp_buf_a = wdata16 & wmask;
         else if (addr_q == OFF_CMP_B)
            next_cmp_buf_b = wdata16 & wmask;
         else if (addr_q == OFF_CAP_TOP)
            next_capture_top_reg = wdata16;
         else if (addr_q == OFF_COUNT)
            next_count_value = wdata16;
         else if (addr_q == OFF_FLAGS)
            next_flags = next_flags & ~(hwdata[3:0] & ~next_flags ^
                         hwdata[3:0] & flags);
      end
      // Compare registers follow buffers outside PWM modes
      if (!is_fast && !is_phase)
      begin
         next_cmp_a = next_cmp_buf_a;
         next_cmp_b = next_cmp_buf_b;
      end

      // Read data registered in the address phase, so it stands in the
      // data phase; next values make a write just landed visible
      if (hsel && hready && htrans[1] && !hwrite)
      begin
         if (haddr == OFF_CTRL)
            next_hrdata = {19'h00000, next_ctrl};
         else if (haddr == OFF_CMP_A)
            next_hrdata = {16'h0000, next_cmp_buf_a};
         else if (haddr == OFF_CMP_B)
            next_hrdata = {16'h0000, next_cmp_buf_b};
         else if (haddr == OFF_CAP_TOP)
            next_hrdata = {16'h0000, next_capture_top_reg};
         else if (haddr == OFF_COUNT)
            next_hrdata = {16'h0000, next_count_value};
         else if (haddr == OFF_FLAGS)
            next_hrdata = {28'h0000000, next_flags};
      end

      // Pin override and direction
      next_pin_a = (output_action_sel_a != ACT_NONE) ? oc_a : port_data_a;
      next_pin_b = (output_action_sel_b != ACT_NONE) ? oc_b : port_data_b;
      next_oe_a_n = !ctrl[CTRL_DIR_A];
      next_oe_b_n = !ctrl[CTRL_DIR_B];
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl <= 13'h0000;
         cmp_buf_a <= CNT_BOTTOM;
         cmp_buf_b <= CNT_BOTTOM;
         cmp_a <= CNT_BOTTOM;
         cmp_b <= CNT_BOTTOM;
         capture_top_reg <= CNT_BOTTOM;
         count_value <= CNT_BOTTOM;
         count_down <= 1'b0;
         flags <= 4'h0;
         oc_a <= 1'b0;
         oc_b <= 1'b0;
         pre_cnt <= 10'h000;
         tick <= 1'b0;
         wr_pend <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= RESET_WORD;
         compare_output_a <= 1'b0;
         compare_output_b <= 1'b0;
         compare_output_a_oe_n <= 1'b1;
         compare_output_b_oe_n <= 1'b1;
      end
      else
      begin
         ctrl <= next_ctrl;
         cmp_buf_a <= next_cmp_buf_a;
         cmp_buf_b <= next_cmp_buf_b;
         cmp_a <= next_cmp_a;
         cmp_b <= next_cmp_b;
         capture_top_reg <= next_capture_top_reg;
         count_value <= next_count_value;
         count_down <= next_count_down;
         flags <= next_flags;
         oc_a <= next_oc_a;
         oc_b <= next_oc_b;
         pre_cnt <= next_pre_cnt;
         tick <= next_tick;
         wr_pend <= next_wr_pend;
         addr_q <= next_addr_q;
         hrdata <= next_hrdata;
         compare_output_a <= next_pin_a;
         compare_output_b <= next_pin_b;
         compare_output_a_oe_n <= next_oe_a_n;
         compare_output_b_oe_n <= next_oe_b_n;
      end
   end

   // Zero wait state, OKAY only
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule : tfp_pwm

/* testbench/testbench.sv */
// Testbench: register-level scenarios for the PWM block.
// Assumes the pin model watches the pad of channel A.
`timescale 1ns/1ns
module testbench;
   import tfp_pkg::*;
   logic hclk = 0;
   logic hresetn = 0;
   logic hsel = 0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 0;
   logic [31:0] hwdata = 32'h0;
   logic port_data_a = 0;
   logic [31:0] hrdata, per, hi, edges, q, h1;
   logic hreadyout, hresp, pad;
   logic compare_output_a, compare_output_b;
   logic compare_output_a_oe_n, compare_output_b_oe_n;
   logic [3:0] m;
   int fail_count = 0;
   int n_compared = 0;
   int e;
   logic [15:0] tops [6] = '{TOP_8, TOP_9, TOP_10, TOP_8, TOP_9, TOP_10};
   logic [3:0] fm [6] = '{TFP_M_FP8, TFP_M_FP9, TFP_M_FP10,
      TFP_M_PC8, TFP_M_PC9, TFP_M_PC10};
   int ns [5] = '{1, 8, 64, 256, 1024};
   always #4 hclk = ~hclk;
   tfp_pwm u_tfp_pwm (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .port_data_a, .port_data_b(1'b0), .compare_output_a,
      .compare_output_b, .compare_output_a_oe_n, .compare_output_b_oe_n);
   tfp_pin_model u_tfp_pin_model (.hclk, .pin_out(compare_output_a),
      .pin_oe_n(compare_output_a_oe_n), .pad, .period(per), .high(hi),
      .edges);
   ///////////////////////////////////////////////
   // Verdict and the single exit point
   task test_done;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   // Bounded wait for ready; a hang ends the run
   task rdy;
      int n;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            chk(0, 1);
            test_done;
         end
         @(posedge hclk);
      end
   endtask : rdy
   // One AHB-Lite single word transfer; read data lands in q
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      q = hrdata;
   endtask : xfer
   function automatic logic [31:0] cw(input logic [3:0] md,
      input logic [1:0] act, input logic [2:0] p);
      cw = 32'h0;
      cw[CTRL_MODE_LSB +: 4] = md;
      cw[CTRL_ACT_A_LSB +: 2] = act;
      cw[CTRL_PRE_LSB +: 3] = p;
      cw[CTRL_DIR_A] = 1'b1;
   endfunction : cw
   // Stop and zero the counter first, so a lower TOP is never overrun
   task cfg(input logic [31:0] c, input logic [15:0] t, input logic [15:0] a);
      xfer(1, OFF_CTRL, 0);
      xfer(1, OFF_COUNT, 0);
      xfer(1, OFF_CAP_TOP, 32'(t));
      xfer(1, OFF_CMP_A, 32'(a));
      xfer(1, OFF_CTRL, c);
   endtask : cfg
   ///////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(0, OFF_CTRL, 0);
      chk(q, RESET_WORD);
      chk(32'(compare_output_a), 0);
      xfer(0, 8'h18, 0);
      chk(q, 0);
      for (int i = 0; i < 6; i++)
      begin
         e = i < 3 ? tops[i] + 1 : 2 * tops[i];
         cfg(cw(fm[i], ACT_NONINV, PRE_1), 0, tops[i] >> 1);
         repeat (3 * e + 20) @(posedge hclk);
         chk(per, 32'(e));
      end
      xfer(1, OFF_CMP_B, 32'h1234);
      xfer(0, OFF_CMP_B, 0);
      chk(q, 32'h0234);
      for (int i = 1; i < 6; i++)
      begin
         e = 4 * ns[i - 1];
         cfg(cw(TFP_M_FPCAP, ACT_NONINV, 3'(i)), 16'h0003, 16'h0001);
         repeat (3 * e + 20) @(posedge hclk);
         chk(per, 32'(e));
      end
      // Inverted and plain high times fill the period exactly
      for (int i = 0; i < 2; i++)
      begin
         m = i ? TFP_M_PCCAP : TFP_M_FPCAP;
         cfg(cw(m, ACT_NONINV, PRE_1), 9, 4);
         repeat (60) @(posedge hclk);
         h1 = hi;
         xfer(1, OFF_CTRL, cw(m, ACT_INV, PRE_1));
         repeat (60) @(posedge hclk);
         chk(h1 + hi, i ? 18 : 10);
      end
      cfg(cw(TFP_M_FPCAP, ACT_NONINV, PRE_1), 9, 0);
      repeat (60) @(posedge hclk);
      chk(32'(hi == 1 || hi == 9), 1);
      cfg(cw(TFP_M_FPCMP, ACT_NONINV, PRE_1), 0, 9);
      repeat (30) @(posedge hclk);
      h1 = edges;
      repeat (60) @(posedge hclk);
      chk(edges, h1);
      xfer(1, OFF_CTRL, cw(TFP_M_FPCMP, ACT_TOGGLE, PRE_1));
      repeat (60) @(posedge hclk);
      chk(per, 20);
      // Flags at TOP, write-one clear; count frozen while stopped
      cfg(cw(TFP_M_FPCAP, ACT_NONINV, PRE_1), 9, 4);
      repeat (30) @(posedge hclk);
      xfer(1, OFF_CTRL, cw(TFP_M_FPCAP, ACT_NONINV, PRE_STOP));
      xfer(0, OFF_FLAGS, 0);
      chk(q & 32'h9, 32'h9);
      xfer(1, OFF_FLAGS, 32'hf);
      xfer(0, OFF_FLAGS, 0);
      chk(q, 0);
      xfer(0, OFF_COUNT, 0);
      h1 = q;
      repeat (20) @(posedge hclk);
      xfer(0, OFF_COUNT, 0);
      chk(q, h1);
      // Count already past the unbuffered TOP: match is missed
      xfer(1, OFF_COUNT, 32'h14);
      xfer(1, OFF_CTRL, cw(TFP_M_FPCAP, ACT_NONINV, PRE_1));
      repeat (300) @(posedge hclk);
      xfer(1, OFF_CTRL, cw(TFP_M_FPCAP, ACT_NONINV, PRE_STOP));
      xfer(0, OFF_FLAGS, 0);
      chk(q & 32'h1, 0);
      xfer(0, OFF_COUNT, 0);
      chk(32'(q[15:0] > 16'h00ff), 1);
      // No action and input direction: port value, pad released
      xfer(1, OFF_CTRL, 0);
      port_data_a <= 1'b1;
      repeat (5) @(posedge hclk);
      chk(32'(compare_output_a), 1);
      chk(32'(pad), 0);
      port_data_a <= 1'b0;
      cfg(cw(TFP_M_FPCAP, ACT_INV, PRE_1), 9, 4);
      repeat (25) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(32'(compare_output_a_oe_n), 1);
      chk(32'(compare_output_a), 0);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      test_done;
   end
endmodule : testbench

/* testbench/tfp_pin_model.sv */
// Pin model: pad of one compare output, with a pull-down.
// Assumes the pad is sampled on hclk; measures rise-to-rise timing.
`timescale 1ns/1ns
module tfp_pin_model
(
   input wire logic hclk,
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic pad,
   output logic [31:0] period,
   output logic [31:0] high,
   output logic [31:0] edges
);
   logic [31:0] t = 0;
   logic [31:0] rise_t = 0;
   logic last = 0;
   // Released pad falls to the pull-down, never holds a stale level
   assign pad = pin_oe_n ? 1'b0 : pin_out;
   // Period, high time and edge count, in hclk cycles
   initial
   begin
      period = 0;
      high = 0;
      edges = 0;
   end
   always @(posedge hclk)
   begin
      t <= t + 1;
      last <= pad;
      if (pad !== last)
         edges <= edges + 1;
      if (pad && !last)
      begin
         period <= t - rise_t;
         rise_t <= t;
      end
      if (!pad && last)
         high <= t - rise_t;
   end
endmodule : tfp_pin_model

/* testbench/tfp_pwm_chk.sv */
// Checker: bus answers and pin control at the block's ports.
// Assumes one AHB-Lite master; bound onto tfp_pwm below.
`timescale 1ns/1ns
module tfp_pwm_chk
   import tfp_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic port_data_a,
   input wire logic compare_output_a,
   input wire logic compare_output_b,
   input wire logic compare_output_a_oe_n,
   input wire logic compare_output_b_oe_n
);
   logic ap_v;
   logic ap_w;
   logic [7:0] ap_a;
   logic [12:0] ctl;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ///////////////////////////////////////////////
   // Shadow of the control word, taken in the data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ap_v <= 1'b0;
         ap_w <= 1'b0;
         ap_a <= 8'h00;
         ctl <= 13'h0000;
      end
      else
      begin
         ap_v <= hsel && hready && htrans[1];
         ap_w <= hwrite;
         ap_a <= haddr;
         if (ap_v && ap_w && ap_a == OFF_CTRL)
            ctl <= hwdata[12:0];
      end
   end
   // Bus answers: zero wait, always OKAY
   a_ready_high: assert property (hreadyout)
      else $error("Ready went low");
   a_resp_okay: assert property (!hresp)
      else $error("Error response seen");
   // Pad enables follow the direction bits once settled
   a_dir_a: assert property (
      $past(ctl, 2) == ctl |-> compare_output_a_oe_n == !ctl[CTRL_DIR_A])
      else $error("Pad A enable wrong");
   a_dir_b: assert property (
      $past(ctl, 2) == ctl |-> compare_output_b_oe_n == !ctl[CTRL_DIR_B])
      else $error("Pad B enable wrong");
   // No action: port value passes through
   a_port_pass: assert property (
      ctl[CTRL_ACT_A_LSB +: 2] == ACT_NONE && $past(ctl, 3) == ctl
      && $stable(port_data_a) && $past(port_data_a, 2) == port_data_a
      |-> compare_output_a == port_data_a)
      else $error("Port value not passed");
   a_unmapped_zero: assert property (
      hsel && hready && htrans[1] && !hwrite && haddr > OFF_FLAGS + 8'h3
      |=> hrdata == 32'h0)
      else $error("Unmapped read not zero");
   a_flags_upper: assert property (
      hsel && hready && htrans[1] && !hwrite && haddr == OFF_FLAGS
      |=> hrdata[31:4] == 28'h0)
      else $error("Flag read has stray bits");
   a_reset_out: assert property ($rose(hresetn) |->
      !compare_output_a && !compare_output_b
      && compare_output_a_oe_n && compare_output_b_oe_n)
      else $error("Outputs not cleared by reset");
endmodule : tfp_pwm_chk

bind tfp_pwm tfp_pwm_chk u_tfp_pwm_chk (.hclk, .hresetn, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
   .port_data_a, .compare_output_a, .compare_output_b,
   .compare_output_a_oe_n, .compare_output_b_oe_n);
